// ==== logic/scd_pkg.sv ====
package scd_pkg;
  localparam int ADDR_W = 16;
  localparam int BA_W = 3;
  localparam int COL_W = 10;
  localparam int NUM_BANKS = 8;
  localparam int SYNC_W = 1 + 6 + BA_W + ADDR_W;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int MR0_BL_LSB = 0;
  localparam logic [BA_W-1:0] MR0_SEL = 3'h0;
  localparam logic [ADDR_W-1:0] MR0_RST = 16'h0000;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  // burst length in link clock periods
  localparam logic [2:0] BURST_CK_BL8 = 3'h4;
  localparam logic [2:0] BURST_CK_BC4 = 3'h2;

  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_MRS = 4'h1,
    CMD_REF = 4'h2,
    CMD_SRE = 4'h3,
    CMD_SRX = 4'h4,
    CMD_PRE = 4'h5,
    CMD_PREA = 4'h6,
    CMD_ACT = 4'h7,
    CMD_WR = 4'h8,
    CMD_RD = 4'h9,
    CMD_PDE = 4'ha,
    CMD_PDX = 4'hb,
    CMD_ZQCL = 4'hc,
    CMD_ZQCS = 4'hd,
    CMD_ILL = 4'hf
  } scd_cmd_e;

  typedef enum logic [2:0] {
    PS_ACT = 3'b001,
    PS_PD = 3'b010,
    PS_SR = 3'b100
  } scd_pwr_e;
endpackage

// ==== logic/scd_cmd_if.sv ====
`timescale 1ns/1ns
interface scd_cmd_if;
  logic cke_prev;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic a10;
  scd_pkg::scd_cmd_e cmd;
  modport dec (input cke_prev, cke, cs_n, ras_n, cas_n, we_n, a10, output cmd);
  modport ctl (output cke_prev, cke, cs_n, ras_n, cas_n, we_n, a10, input cmd);
endinterface

// ==== logic/scd_decode.sv ====
`timescale 1ns/1ns
module scd_decode (
  scd_cmd_if.dec cif // sampled strobes in, command out
);
  always_comb begin
    cif.cmd = scd_pkg::CMD_ILL;
    case ({cif.cke_prev, cif.cke})
      2'b11: begin
        if (cif.cs_n) begin
          cif.cmd = scd_pkg::CMD_NOP;
        end else begin
          case ({cif.ras_n, cif.cas_n, cif.we_n})
            3'b000: cif.cmd = scd_pkg::CMD_MRS;
            3'b001: cif.cmd = scd_pkg::CMD_REF;
            3'b010: cif.cmd = cif.a10 ? scd_pkg::CMD_PREA : scd_pkg::CMD_PRE;
            3'b011: cif.cmd = scd_pkg::CMD_ACT;
            3'b100: cif.cmd = scd_pkg::CMD_WR;
            3'b101: cif.cmd = scd_pkg::CMD_RD;
            3'b110: cif.cmd = cif.a10 ? scd_pkg::CMD_ZQCL : scd_pkg::CMD_ZQCS;
            default: cif.cmd = scd_pkg::CMD_NOP;
          endcase
        end
      end
      2'b10: begin
        if (cif.cs_n || {cif.ras_n, cif.cas_n, cif.we_n} == 3'b111) begin
          cif.cmd = scd_pkg::CMD_PDE;
        end else if ({cif.ras_n, cif.cas_n, cif.we_n} == 3'b001) begin
          cif.cmd = scd_pkg::CMD_SRE;
        end else begin
          cif.cmd = scd_pkg::CMD_ILL;
        end
      end
      2'b01: begin
        if (cif.cs_n || {cif.ras_n, cif.cas_n, cif.we_n} == 3'b111) begin
          cif.cmd = scd_pkg::CMD_PDX;
        end else begin
          cif.cmd = scd_pkg::CMD_ILL;
        end
      end
      default: cif.cmd = scd_pkg::CMD_NOP;
    endcase
  end
endmodule // scd_decode

// ==== logic/scd_top.sv ====
`timescale 1ns/1ns
module scd_top (
  input wire logic core_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic mem_reset_n, // device reset pin
  input wire logic ck, // link clock pin
  input wire logic cke, // clock enable pin
  input wire logic cs_n, // chip select
  input wire logic ras_n, // row strobe
  input wire logic cas_n, // column strobe
  input wire logic we_n, // write enable
  input wire logic odt, // termination request
  input wire logic [scd_pkg::BA_W-1:0] ba, // bank address
  input wire logic [scd_pkg::ADDR_W-1:0] addr, // address lines
  output scd_pkg::scd_cmd_e cmd_o, // last accepted command
  output logic cmd_valid_o, // pulse per accepted command
  output logic [scd_pkg::BA_W-1:0] bank_o, // bank of last command
  output logic [scd_pkg::ADDR_W-1:0] row_o, // row of last activate
  output logic [scd_pkg::COL_W-1:0] col_o, // column of last burst
  output logic mr_wr_o, // mode register write pulse
  output logic [scd_pkg::BA_W-1:0] mr_sel_o, // mode register index
  output logic [scd_pkg::ADDR_W-1:0] mr_op_o, // mode register op code
  output logic burst_active_o, // burst running
  output logic burst_write_o, // running burst is a write
  output logic burst_bc4_o, // burst chop four
  output logic auto_pre_o, // auto precharge pending
  output logic rw_reject_o, // pulse: burst command refused
  output logic [scd_pkg::NUM_BANKS-1:0] bank_open_o, // open banks
  output logic power_down_o, // in power-down
  output logic self_refresh_o, // in self-refresh
  output logic odt_en_o // termination enabled
);
  logic [1:0] rsync_r;
  logic rst_all;
  logic [scd_pkg::SYNC_W-1:0] s1_r;
  logic [scd_pkg::SYNC_W-1:0] s2_r;
  logic ck_d_r;
  logic ck_s;
  logic cke_s;
  logic odt_s;
  logic ck_rise;
  logic cke_prev_r;
  logic [scd_pkg::BA_W-1:0] ba_s;
  logic [scd_pkg::ADDR_W-1:0] addr_s;
  logic [scd_pkg::ADDR_W-1:0] mr0_r;
  logic [2:0] beats_r;
  logic burst_end;
  logic rw_cmd;
  logic rw_take;
  logic bc4_sel;
  scd_pkg::scd_pwr_e pwr_r;
  scd_pkg::scd_pwr_e pwr_nxt;
  scd_pkg::scd_cmd_e cmd_now;

  scd_cmd_if cif ();

  // device reset pin asserts asynchronously, releases synchronously
  always_ff @(posedge core_clk or posedge rst or negedge mem_reset_n) begin
    if (rst || !mem_reset_n) begin
      rsync_r <= 2'h0;
    end else begin
      rsync_r <= {rsync_r[0], 1'b1};
    end
  end
  assign rst_all = rst || !rsync_r[1];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_r <= '0;
      s2_r <= '0;
      ck_d_r <= 1'b0;
    end else begin
      s1_r <= {ck, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr};
      s2_r <= s1_r;
      ck_d_r <= ck_s;
    end
  end

  assign {ck_s, cke_s, cif.cs_n, cif.ras_n, cif.cas_n, cif.we_n, odt_s, ba_s, addr_s} = s2_r;
  assign ck_rise = ck_s && !ck_d_r;
  assign cif.cke_prev = cke_prev_r;
  assign cif.cke = cke_s;
  assign cif.a10 = addr_s[scd_pkg::AP_BIT];

  scd_decode u_dec (
    .cif(cif)
  );

  // nothing is decoded between link clock rises
  assign cmd_now = ck_rise ? cif.cmd : scd_pkg::CMD_NOP;
  assign rw_cmd = cmd_now == scd_pkg::CMD_WR || cmd_now == scd_pkg::CMD_RD;
  assign rw_take = rw_cmd && !burst_active_o && pwr_r == scd_pkg::PS_ACT;
  assign burst_end = burst_active_o && ck_rise && beats_r == 3'h1;

  always_comb begin
    case (mr0_r[scd_pkg::MR0_BL_LSB +: 2])
      scd_pkg::BL_OTF: bc4_sel = !addr_s[scd_pkg::BC_BIT];
      scd_pkg::BL_FIXED4: bc4_sel = 1'b1;
      default: bc4_sel = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst_all) begin
    if (rst_all) begin
      cke_prev_r <= 1'b0;
    end else if (ck_rise) begin
      cke_prev_r <= cke_s;
    end
  end

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      scd_pkg::PS_ACT: begin
        if (cmd_now == scd_pkg::CMD_SRE) begin
          pwr_nxt = scd_pkg::PS_SR;
        end else if (cmd_now == scd_pkg::CMD_PDE) begin
          pwr_nxt = scd_pkg::PS_PD;
        end
      end
      scd_pkg::PS_PD: begin
        if (cmd_now == scd_pkg::CMD_PDX) begin
          pwr_nxt = scd_pkg::PS_ACT;
        end
      end
      scd_pkg::PS_SR: begin
        if (cke_s) begin
          pwr_nxt = scd_pkg::PS_ACT;
        end
      end
      default: pwr_nxt = scd_pkg::PS_ACT;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst_all) begin
    if (rst_all) begin
      pwr_r <= scd_pkg::PS_ACT;
      power_down_o <= 1'b0;
      self_refresh_o <= 1'b0;
      odt_en_o <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      power_down_o <= pwr_nxt == scd_pkg::PS_PD;
      self_refresh_o <= pwr_nxt == scd_pkg::PS_SR;
      odt_en_o <= odt_s && pwr_nxt != scd_pkg::PS_SR;
    end
  end

  // command report; nop and deselect leave no trace, refused commands only pulse rw_reject_o
  always_ff @(posedge core_clk or posedge rst_all) begin
    if (rst_all) begin
      cmd_o <= scd_pkg::CMD_NOP;
      cmd_valid_o <= 1'b0;
      bank_o <= '0;
      rw_reject_o <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      rw_reject_o <= rw_cmd && !rw_take;
      if (pwr_r == scd_pkg::PS_SR && cke_s) begin
        cmd_o <= scd_pkg::CMD_SRX;
        cmd_valid_o <= 1'b1;
      end else if (cmd_now != scd_pkg::CMD_NOP && (!rw_cmd || rw_take)) begin
        if (cmd_now == scd_pkg::CMD_REF && pwr_r != scd_pkg::PS_ACT) begin
          cmd_o <= scd_pkg::CMD_ILL;
        end else begin
          cmd_o <= cmd_now;
        end
        cmd_valid_o <= 1'b1;
        bank_o <= ba_s;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst_all) begin
    if (rst_all) begin
      mr_wr_o <= 1'b0;
      mr_sel_o <= '0;
      mr_op_o <= '0;
      mr0_r <= scd_pkg::MR0_RST;
    end else begin
      mr_wr_o <= cmd_now == scd_pkg::CMD_MRS;
      if (cmd_now == scd_pkg::CMD_MRS) begin
        mr_sel_o <= ba_s;
        mr_op_o <= addr_s;
        if (ba_s == scd_pkg::MR0_SEL) begin
          mr0_r <= addr_s;
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst_all) begin
    if (rst_all) begin
      burst_active_o <= 1'b0;
      burst_write_o <= 1'b0;
      burst_bc4_o <= 1'b0;
      auto_pre_o <= 1'b0;
      beats_r <= 3'h0;
      col_o <= '0;
    end else if (rw_take) begin
      burst_active_o <= 1'b1;
      burst_write_o <= cmd_now == scd_pkg::CMD_WR;
      burst_bc4_o <= bc4_sel;
      auto_pre_o <= addr_s[scd_pkg::AP_BIT];
      beats_r <= bc4_sel ? scd_pkg::BURST_CK_BC4 : scd_pkg::BURST_CK_BL8;
      col_o <= addr_s[scd_pkg::COL_W-1:0];
    end else if (burst_end) begin
      burst_active_o <= 1'b0;
      auto_pre_o <= 1'b0;
      beats_r <= 3'h0;
    end else if (burst_active_o && ck_rise) begin
      beats_r <= beats_r - 3'h1;
    end
  end

  generate
    for (genvar b = 0; b < scd_pkg::NUM_BANKS; b++) begin : g_bank
      always_ff @(posedge core_clk or posedge rst_all) begin
        if (rst_all) begin
          bank_open_o[b] <= 1'b0;
        end else if (cmd_now == scd_pkg::CMD_PREA) begin
          bank_open_o[b] <= 1'b0;
        end else if (ba_s == scd_pkg::BA_W'(b) && cmd_now == scd_pkg::CMD_ACT) begin
          bank_open_o[b] <= 1'b1;
        end else if (ba_s == scd_pkg::BA_W'(b) && cmd_now == scd_pkg::CMD_PRE) begin
          bank_open_o[b] <= 1'b0;
        end else if (burst_end && auto_pre_o && bank_o == scd_pkg::BA_W'(b)) begin
          bank_open_o[b] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst_all) begin
    if (rst_all) begin
      row_o <= '0;
    end else if (cmd_now == scd_pkg::CMD_ACT) begin
      row_o <= addr_s;
    end
  end

  AST_MRS_TAKE: assert property (@(posedge core_clk) disable iff (rst_all)
    cmd_now == scd_pkg::CMD_MRS |=> mr_wr_o && mr_sel_o == $past(ba_s) && mr_op_o == $past(addr_s))
    else $error("mode register write not captured");
  AST_WR_DEC: assert property (@(posedge core_clk) disable iff (rst_all)
    ck_rise && cke_prev_r && cke_s && {cif.cs_n, cif.ras_n, cif.cas_n, cif.we_n} == 4'h4 |-> cmd_now == scd_pkg::CMD_WR)
    else $error("write pattern not decoded");
  AST_RD_DEC: assert property (@(posedge core_clk) disable iff (rst_all)
    ck_rise && cke_prev_r && cke_s && {cif.cs_n, cif.ras_n, cif.cas_n, cif.we_n} == 4'h5 |-> cmd_now == scd_pkg::CMD_RD)
    else $error("read pattern not decoded");
  AST_DES_NOP: assert property (@(posedge core_clk) disable iff (rst_all)
    ck_rise && cke_prev_r && cke_s && cif.cs_n |=> !cmd_valid_o || cmd_o == scd_pkg::CMD_SRX)
    else $error("deselect produced a command");
  AST_OTF_BC: assert property (@(posedge core_clk) disable iff (rst_all)
    rw_take && mr0_r[1:0] == scd_pkg::BL_OTF |=> burst_bc4_o == !$past(addr_s[scd_pkg::BC_BIT]))
    else $error("on-the-fly burst length wrong");
  AST_FIXED_BL8: assert property (@(posedge core_clk) disable iff (rst_all)
    rw_take && mr0_r[1:0] == scd_pkg::BL_FIXED8 |=> !burst_bc4_o)
    else $error("fixed burst of eight chopped");
  AST_AUTO_PRE: assert property (@(posedge core_clk) disable iff (rst_all)
    rw_take |=> auto_pre_o == $past(addr_s[scd_pkg::AP_BIT]) && burst_active_o)
    else $error("auto precharge flag wrong");
  AST_NO_CUT: assert property (@(posedge core_clk) disable iff (rst_all)
    burst_active_o && rw_cmd |=> rw_reject_o && $stable(col_o) && burst_active_o == !$past(burst_end))
    else $error("running burst interrupted");
  AST_ACT_OPEN: assert property (@(posedge core_clk) disable iff (rst_all)
    cmd_now == scd_pkg::CMD_ACT |=> bank_open_o[$past(ba_s)] && bank_o == $past(ba_s))
    else $error("activate did not open bank");
  AST_PREA: assert property (@(posedge core_clk) disable iff (rst_all)
    cmd_now == scd_pkg::CMD_PREA |=> bank_open_o == '0)
    else $error("precharge all left a bank open");
  AST_SRX_ASYNC: assert property (@(posedge core_clk) disable iff (rst_all)
    pwr_r == scd_pkg::PS_SR && cke_s && !ck_rise |=> !self_refresh_o && cmd_o == scd_pkg::CMD_SRX)
    else $error("self-refresh exit waited for clock");
  AST_SR_ODT: assert property (@(posedge core_clk) disable iff (rst_all)
    self_refresh_o |-> !odt_en_o)
    else $error("termination on in self-refresh");
  AST_PD_NOREF: assert property (@(posedge core_clk) disable iff (rst_all)
    power_down_o && cmd_valid_o |-> cmd_o != scd_pkg::CMD_REF)
    else $error("refresh in power-down");
  AST_PDE: assert property (@(posedge core_clk) disable iff (rst_all)
    ck_rise && pwr_r == scd_pkg::PS_ACT && cke_prev_r && !cke_s &&
    (cif.cs_n || {cif.ras_n, cif.cas_n, cif.we_n} == 3'b111) |=> power_down_o)
    else $error("power-down entry missed");
  AST_NOP_QUIET: assert property (@(posedge core_clk) disable iff (rst_all)
    ck_rise && cif.cmd == scd_pkg::CMD_NOP && pwr_r == scd_pkg::PS_ACT |=> !cmd_valid_o && !mr_wr_o)
    else $error("no-operation registered work");
  AST_PIN_RESET: assert property (@(posedge core_clk) disable iff (rst)
    !mem_reset_n |=> bank_open_o == '0 && !burst_active_o && !cmd_valid_o)
    else $error("reset pin not honoured");
endmodule // scd_top

// ==== verification/scd_ctl_model.sv ====
`timescale 1ns/1ns
module scd_ctl_model (
  input wire logic core_clk, // system clock
  output logic mem_reset_n, // device reset pin
  output logic ck, // link clock
  output logic cke, // clock enable
  output logic cs_n, // chip select
  output logic ras_n, // row strobe
  output logic cas_n, // column strobe
  output logic we_n, // write enable
  output logic odt, // termination request
  output logic [scd_pkg::BA_W-1:0] ba, // bank address
  output logic [scd_pkg::ADDR_W-1:0] addr // address lines
);
  // refresh interval in ns at extended temperature
  localparam int REFI_EXT_NS = 3900;
  localparam int CLK_NS = 10;
  initial begin
    mem_reset_n = 1'b1;
    ck = 1'b0;
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h17;
    odt = 1'b0;
    ba = 3'h0;
    addr = 16'h0000;
  end
  // pins {cke, cs_n, ras_n, cas_n, we_n}; held well around the clock rise
  task automatic frame(input logic [4:0] pins, input logic [2:0] b, input logic [15:0] a);
    @(negedge core_clk);
    {cke, cs_n, ras_n, cas_n, we_n} = pins;
    ba = b;
    addr = a;
    repeat (8) @(negedge core_clk);
    ck = 1'b1;
    repeat (8) @(negedge core_clk);
    ck = 1'b0;
    repeat (3) @(negedge core_clk);
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    ba = ~b;
    addr = ~a;
  endtask
  // clock enable and termination change with the link clock stopped
  task automatic level(input logic c, input logic o);
    @(negedge core_clk);
    cke = c;
    odt = o;
    repeat (8) @(negedge core_clk);
  endtask
  task automatic pulse_reset;
    @(negedge core_clk);
    mem_reset_n = 1'b0;
    repeat (3) @(negedge core_clk);
    mem_reset_n = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
  // two refreshes one extended-range interval apart, rise to rise
  task automatic refresh_pair;
    frame(5'h11, 3'h0, 16'h0000);
    repeat (REFI_EXT_NS / CLK_NS - 20) @(negedge core_clk);
    frame(5'h11, 3'h0, 16'h0000);
  endtask
endmodule // scd_ctl_model

// ==== verification/sdram_command_decoder_tb.sv ====
`timescale 1ns/1ns
module sdram_command_decoder_tb;
  localparam logic [4:0] P_NOP = 5'h17;
  localparam logic [4:0] P_DES = 5'h18;
  localparam logic [4:0] P_MRS = 5'h10;
  localparam logic [4:0] P_ACT = 5'h13;
  localparam logic [4:0] P_WR = 5'h14;
  localparam logic [4:0] P_RD = 5'h15;
  localparam logic [3:0] SKIP = 4'he;
  logic core_clk, rst, mem_reset_n, ck, cke, cs_n, ras_n, cas_n, we_n, odt;
  logic [2:0] ba, bank_o, mr_sel_o;
  logic [15:0] addr, row_o, mr_op_o;
  logic [9:0] col_o;
  logic [7:0] bank_open_o;
  logic cmd_valid_o, mr_wr_o, burst_active_o, burst_write_o, burst_bc4_o, auto_pre_o;
  logic rw_reject_o, power_down_o, self_refresh_o, odt_en_o;
  scd_pkg::scd_cmd_e cmd_o, last_cmd;
  int errors = 0;
  int samples_checked = 0;
  int vcount = 0;
  int rcount = 0;
  int mcount = 0;
  int r0;
  logic [4:0] tp [5] = '{5'h11, 5'h12, 5'h12, 5'h16, 5'h16};
  logic [15:0] ta [5] = '{16'h0000, 16'h0000, 16'h0400, 16'h0400, 16'h0000};
  logic [3:0] tc [5] = '{4'h2, 4'h5, 4'h6, 4'hc, 4'hd};

  scd_ctl_model ctl (.core_clk(core_clk), .mem_reset_n(mem_reset_n), .ck(ck), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba), .addr(addr));
  scd_top DUT (.core_clk(core_clk), .rst(rst), .mem_reset_n(mem_reset_n), .ck(ck), .cke(cke), .cs_n(cs_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .odt(odt), .ba(ba), .addr(addr), .cmd_o(cmd_o),
    .cmd_valid_o(cmd_valid_o), .bank_o(bank_o), .row_o(row_o), .col_o(col_o), .mr_wr_o(mr_wr_o),
    .mr_sel_o(mr_sel_o), .mr_op_o(mr_op_o), .burst_active_o(burst_active_o), .burst_write_o(burst_write_o),
    .burst_bc4_o(burst_bc4_o), .auto_pre_o(auto_pre_o), .rw_reject_o(rw_reject_o),
    .bank_open_o(bank_open_o), .power_down_o(power_down_o), .self_refresh_o(self_refresh_o),
    .odt_en_o(odt_en_o));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // pulses are registered, so they are settled at the falling edge
  always @(negedge core_clk) begin
    if (cmd_valid_o === 1'b1) begin
      vcount++;
      last_cmd = cmd_o;
    end
    if (rw_reject_o === 1'b1) rcount++;
    if (mr_wr_o === 1'b1) mcount++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // one frame; a quiet code expects no cmd_valid_o pulse
  task automatic run(input logic [4:0] pins, input logic [2:0] b, input logic [15:0] a, input logic [3:0] exp);
    int v0;
    v0 = vcount;
    ctl.frame(pins, b, a);
    if (exp != SKIP) check("pulses", vcount - v0, (exp == 4'h0) ? 0 : 1);
    if (exp != SKIP && exp != 4'h0) check("cmd", last_cmd, exp);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    errors++;
    print_verdict;
  end

  initial begin
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    repeat (4) @(negedge core_clk);
    check("cmd_reset", cmd_o, 4'h0);
    run(P_NOP, 3'h0, 16'h0000, 4'hb);
    run(P_NOP, 3'h0, 16'h0000, 4'h0);
    run(P_DES, 3'h0, 16'h0000, 4'h0);
    run(P_MRS, 3'h2, 16'h0040, 4'h1);
    check("mr_sel", mr_sel_o, 3'h2);
    check("mr_op", mr_op_o, 16'h0040);
    check("mr_pulses", mcount, 1);
    run(P_ACT, 3'h3, 16'h1234, 4'h7);
    check("row", row_o, 16'h1234);
    check("open", bank_open_o, 8'h08);
    run(P_WR, 3'h3, 16'h0405, 4'h8);
    check("col", col_o, 10'h005);
    check("bank", bank_o, 3'h3);
    check("wr_flags", {burst_active_o, burst_write_o, burst_bc4_o, auto_pre_o}, 4'hd);
    r0 = rcount;
    run(P_RD, 3'h3, 16'h0000, SKIP);
    check("reject", rcount - r0, 1);
    run(P_DES, 3'h3, 16'h0000, 4'h0);
    run(P_NOP, 3'h0, 16'h0000, 4'h0);
    check("busy", burst_active_o, 1'b1);
    run(P_NOP, 3'h0, 16'h0000, 4'h0);
    check("done", burst_active_o, 1'b0);
    check("auto_close", bank_open_o, 8'h00);
    run(P_MRS, 3'h0, 16'h0001, 4'h1);
    run(P_RD, 3'h1, 16'h0007, 4'h9);
    check("col_rd", col_o, 10'h007);
    check("rd_flags", {burst_active_o, burst_write_o, burst_bc4_o, auto_pre_o}, 4'ha);
    run(P_NOP, 3'h0, 16'h0000, 4'h0);
    check("bc4_busy", burst_active_o, 1'b1);
    run(P_NOP, 3'h0, 16'h0000, 4'h0);
    check("bc4_done", burst_active_o, 1'b0);
    run(P_RD, 3'h1, 16'h1008, 4'h9);
    check("bl8", burst_bc4_o, 1'b0);
    repeat (3) run(P_NOP, 3'h0, 16'h0000, 4'h0);
    check("bl8_busy", burst_active_o, 1'b1);
    run(P_NOP, 3'h0, 16'h0000, 4'h0);
    check("bl8_done", burst_active_o, 1'b0);
    run(P_MRS, 3'h0, 16'h0002, 4'h1);
    run(P_RD, 3'h1, 16'h1000, 4'h9);
    check("fixed_bc4", burst_bc4_o, 1'b1);
    repeat (2) run(P_NOP, 3'h0, 16'h0000, 4'h0);
    check("fixed_done", burst_active_o, 1'b0);
    for (int i = 0; i < 5; i++) run(tp[i], 3'h1, ta[i], tc[i]);
    r0 = vcount;
    ctl.refresh_pair;
    check("ref_pair", {28'(vcount - r0), last_cmd}, {28'h2, 4'h2});
    run(5'h03, 3'h0, 16'h0000, 4'hf);
    run(P_NOP, 3'h0, 16'h0000, 4'hb);
    run(5'h07, 3'h0, 16'h0000, 4'ha);
    check("pd_on", power_down_o, 1'b1);
    run(P_NOP, 3'h0, 16'h0000, 4'hb);
    check("pd_off", power_down_o, 1'b0);
    ctl.level(1'b1, 1'b1);
    check("odt_on", odt_en_o, 1'b1);
    run(5'h01, 3'h0, 16'h0000, 4'h3);
    check("sr_on", self_refresh_o, 1'b1);
    check("odt_sr", odt_en_o, 1'b0);
    r0 = vcount;
    ctl.level(1'b1, 1'b1);
    check("sr_off", self_refresh_o, 1'b0);
    check("srx", {28'(vcount - r0), last_cmd}, {28'h1, 4'h4});
    check("odt_back", odt_en_o, 1'b1);
    run(P_NOP, 3'h0, 16'h0000, SKIP);
    run(P_ACT, 3'h5, 16'h0abc, 4'h7);
    check("open5", bank_open_o, 8'h20);
    ctl.pulse_reset;
    check("pin_reset", {bank_open_o, cmd_o}, 12'h000);
    print_verdict;
  end
endmodule // sdram_command_decoder_tb
